// ### include/sgl_consts.vh
// Constants for the strap, general-purpose pin and LED control block.
// Assumes a single 20 MHz clock and word-aligned AXI4-Lite byte addresses.
`ifndef SGL_CONSTS_VH
`define SGL_CONSTS_VH

// Clock and timing
`define SGL_CLK_HZ 20000000
`define SGL_BLINK_MS 50

// Register byte offsets
`define SGL_OFS_STATUS 5'h00
`define SGL_OFS_ADVERT 5'h04
`define SGL_OFS_STRAPS 5'h08
`define SGL_OFS_PINCTL 5'h0c
`define SGL_OFS_IRQCTL 5'h10

// Pin control register fields
`define SGL_PIN_GP0_DIR 6
`define SGL_PIN_GP0_DAT 7
`define SGL_PIN_GP1_DIR 8
`define SGL_PIN_GP1_DAT 9
`define SGL_PIN_IRQ_POL 14
`define SGL_PIN_RPT 15
`define SGL_PINCTL_RST 16'h0140
`define SGL_PINCTL_MASK 16'hc3c0

// Interrupt control register fields
`define SGL_IRQ_EN_LSB 0
`define SGL_IRQ_ST_LSB 8
`define SGL_IRQ_EVENTS 8

// Ability field layout (status and advertisement)
`define SGL_AB_10HD 0
`define SGL_AB_10FD 1
`define SGL_AB_100HD 2
`define SGL_AB_100FD 3
`define SGL_AB_ANEG 4
`define SGL_AB_WIDTH 5

// Bus responses
`define SGL_RESP_OKAY 2'b00
`define SGL_RESP_SLVERR 2'b10

`endif

// ### rtl/sgl_strap_gpio_led.v
// Strap latching, two general-purpose pins, interrupt pin and status LEDs,
// with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to clk and that shared strap pins are
// held by board resistors while resetn is low and just after its release.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`include "sgl_consts.vh"

module sgl_strap_gpio_led #(
  parameter BLINK_CYCLES = `SGL_BLINK_MS * (`SGL_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // AXI4-Lite slave
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // General-purpose pins, shared with straps
  input wire gpio0_in,
  output reg gpio0_out,
  output reg gpio0_oe_n,
  input wire gpio1_in,
  output reg gpio1_out,
  output reg gpio1_oe_n,
  // Interrupt pin
  output reg irq_out,
  output reg irq_out_oe_n,
  // Plain strap inputs
  input wire [2:0] tech_sel_strap,
  input wire autoneg_ability_strap,
  input wire repeater_strap,
  // LED pins shared with straps
  input wire receive_led_in,
  output reg receive_led,
  output reg receive_led_oe_n,
  input wire collision_led_in,
  output reg collision_led,
  output reg collision_led_oe_n,
  input wire fast_speed_led_in,
  output reg fast_speed_led,
  output reg fast_speed_led_oe_n,
  // Output-only LED pins
  output reg link_led,
  output reg transmit_led,
  // Status from the data path
  input wire rx_active,
  input wire tx_active,
  input wire collision,
  input wire link_up,
  input wire speed_100,
  input wire full_duplex,
  input wire coding_bypass_mode,
  input wire bypass_signal_detect,
  input wire [7:0] irq_events,
  // Configuration to the rest of the device
  output reg seven_wire_serial_mode,
  output reg transformer_ratio_strap,
  output reg scrambler_enable,
  output reg fibre_mode,
  output reg autoneg_enable,
  output reg repeater_mode,
  output reg advanced_leds
);

  localparam [15:0] PIN_MASK = `SGL_PINCTL_MASK;
  localparam [31:0] BLINK_LAST = BLINK_CYCLES - 1;

  // Register index decode, shared by the read and write paths
  function [2:0] reg_sel;
    input [4:0] addr;
    begin
      if (addr == `SGL_OFS_STATUS) reg_sel = 3'h1;
      else if (addr == `SGL_OFS_ADVERT) reg_sel = 3'h2;
      else if (addr == `SGL_OFS_STRAPS) reg_sel = 3'h3;
      else if (addr == `SGL_OFS_PINCTL) reg_sel = 3'h4;
      else if (addr == `SGL_OFS_IRQCTL) reg_sel = 3'h5;
      else reg_sel = 3'h0;
    end
  endfunction

  // Strap capture
  reg strap_done_q, led_style_strap_q;
  reg [2:0] tech_sel_q;
  reg [`SGL_AB_WIDTH-1:0] cap_q;
  // Registers
  reg [15:0] pinctl_q;
  reg [7:0] irq_en_q, irq_st_q;
  reg [`SGL_AB_WIDTH-1:0] adv_q;
  // Bus state
  reg aw_have_q, w_have_q;
  reg [4:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  // Blink divider
  reg [31:0] blink_cnt_q;
  reg blink_q;

  wire [`SGL_AB_WIDTH-1:0] cap_d;
  wire [31:0] wmask;
  wire [2:0] wsel, rsel;
  wire wr_go, irq_pending, gp0_rd, gp1_rd;

  // Abilities from straps: bit 2 gives 10 Mbps, bit 1 gives 100 Mbps,
  // bit 0 adds full duplex to each speed enabled.
  assign cap_d[`SGL_AB_10HD] = tech_sel_q[2];
  assign cap_d[`SGL_AB_10FD] = tech_sel_q[2] & tech_sel_q[0];
  assign cap_d[`SGL_AB_100HD] = tech_sel_q[1];
  assign cap_d[`SGL_AB_100FD] = tech_sel_q[1] & tech_sel_q[0];
  assign cap_d[`SGL_AB_ANEG] = autoneg_enable;

  // Straps are taken at the first edge after reset release, while every
  // shared pin is still undriven; afterwards the pins may serve as outputs.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
      seven_wire_serial_mode <= 1'b0;
      transformer_ratio_strap <= 1'b0;
      scrambler_enable <= 1'b1;
      fibre_mode <= 1'b0;
      autoneg_enable <= 1'b1;
      led_style_strap_q <= 1'b1;
      tech_sel_q <= 3'h7;
      cap_q <= {`SGL_AB_WIDTH{1'b0}};
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      seven_wire_serial_mode <= ~gpio0_in;
      transformer_ratio_strap <= gpio1_in;
      scrambler_enable <= collision_led_in;
      fibre_mode <= ~fast_speed_led_in;
      autoneg_enable <= autoneg_ability_strap;
      led_style_strap_q <= receive_led_in;
      tech_sel_q <= tech_sel_strap;
    end else begin
      cap_q <= cap_d;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      advanced_leds <= 1'b0;
    else
      advanced_leds <= ~led_style_strap_q;
  end

  // Bus handshakes; address and data are taken in either order
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wsel = reg_sel(awaddr_q);
  assign rsel = reg_sel(s_axi_araddr);
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                  {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SGL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == 3'h0) ? `SGL_RESP_SLVERR : `SGL_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinctl_q <= `SGL_PINCTL_RST;
      irq_en_q <= 8'h00;
      irq_st_q <= 8'h00;
      adv_q <= {`SGL_AB_WIDTH{1'b1}};
    end else begin
      // Clamp to the live strap abilities; the captured copy lags a cycle
      if (!strap_done_q)
        adv_q <= {`SGL_AB_WIDTH{1'b1}};
      else if (wr_go && wsel == 3'h2)
        adv_q <= (wdata_q[`SGL_AB_WIDTH-1:0] & wmask[`SGL_AB_WIDTH-1:0]
                  | adv_q & ~wmask[`SGL_AB_WIDTH-1:0]) & cap_d;
      else
        adv_q <= adv_q & cap_d;
      if (wr_go && wsel == 3'h4)
        pinctl_q <= (wdata_q[15:0] & wmask[15:0] & PIN_MASK)
                    | (pinctl_q & ~(wmask[15:0] & PIN_MASK));
      if (wr_go && wsel == 3'h5 && wstrb_q[0])
        irq_en_q <= wdata_q[`SGL_IRQ_EN_LSB +: `SGL_IRQ_EVENTS];
      // A new event wins over a clear in the same cycle
      if (wr_go && wsel == 3'h5 && wstrb_q[1])
        irq_st_q <= (irq_st_q & ~wdata_q[`SGL_IRQ_ST_LSB +: `SGL_IRQ_EVENTS])
                    | irq_events;
      else
        irq_st_q <= irq_st_q | irq_events;
    end
  end

  // Data bits read the pin when it is an input
  assign gp0_rd = pinctl_q[`SGL_PIN_GP0_DIR] ? gpio0_in
                : pinctl_q[`SGL_PIN_GP0_DAT];
  assign gp1_rd = pinctl_q[`SGL_PIN_GP1_DIR] ? gpio1_in
                : pinctl_q[`SGL_PIN_GP1_DAT];

  // Read path; one cycle from address taken to data valid
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SGL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SGL_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (rsel == 3'h1)
        s_axi_rdata <= {26'h000_0000, link_up, cap_q};
      else if (rsel == 3'h2)
        s_axi_rdata <= {27'h000_0000, adv_q};
      else if (rsel == 3'h3)
        s_axi_rdata <= {23'h00_0000, advanced_leds, fibre_mode,
                        scrambler_enable, autoneg_enable, tech_sel_q,
                        transformer_ratio_strap, seven_wire_serial_mode};
      else if (rsel == 3'h4)
        s_axi_rdata <= {16'h0000, pinctl_q[15:10], gp1_rd,
                        pinctl_q[8], gp0_rd, pinctl_q[6:0]};
      else if (rsel == 3'h5)
        s_axi_rdata <= {16'h0000, irq_st_q, irq_en_q};
      else
        s_axi_rresp <= `SGL_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt pin: floats unless an enabled event is pending
  assign irq_pending = |(irq_st_q & irq_en_q);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_out <= 1'b0;
      irq_out_oe_n <= 1'b1;
      repeater_mode <= 1'b0;
    end else begin
      irq_out <= pinctl_q[`SGL_PIN_IRQ_POL];
      irq_out_oe_n <= ~irq_pending;
      repeater_mode <= repeater_strap | pinctl_q[`SGL_PIN_RPT];
    end
  end

  // General-purpose pins stay undriven until straps are captured
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpio0_out <= 1'b0;
      gpio0_oe_n <= 1'b1;
      gpio1_out <= 1'b0;
      gpio1_oe_n <= 1'b1;
    end else begin
      gpio0_out <= pinctl_q[`SGL_PIN_GP0_DAT];
      gpio0_oe_n <= ~strap_done_q | pinctl_q[`SGL_PIN_GP0_DIR];
      gpio1_out <= pinctl_q[`SGL_PIN_GP1_DAT];
      gpio1_oe_n <= ~strap_done_q | pinctl_q[`SGL_PIN_GP1_DIR];
    end
  end

  // Shared blink divider; visible rate traded against a long counter
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= BLINK_LAST) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // LED drive; active low, high means off, except link_led in seven-wire or bypass mode (high on link or signal detect) and the bicolour pair (low when off)
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      receive_led <= 1'b1;
      receive_led_oe_n <= 1'b1;
      collision_led <= 1'b1;
      collision_led_oe_n <= 1'b1;
      fast_speed_led <= 1'b1;
      fast_speed_led_oe_n <= 1'b1;
      link_led <= 1'b1;
      transmit_led <= 1'b1;
    end else begin
      receive_led_oe_n <= ~strap_done_q;
      collision_led_oe_n <= ~strap_done_q;
      fast_speed_led_oe_n <= ~strap_done_q;
      receive_led <= rx_active ? blink_q : 1'b1;
      collision_led <= (collision & ~full_duplex) ? blink_q : 1'b1;
      if (coding_bypass_mode)
        link_led <= bypass_signal_detect;
      else if (seven_wire_serial_mode)
        link_led <= link_up;
      else
        link_led <= ~link_up;
      if (!advanced_leds) begin
        fast_speed_led <= ~speed_100;
        transmit_led <= tx_active ? blink_q : 1'b1;
      end else if (link_up && !(rx_active && blink_q)) begin
        // Colour shows duplex, the pair is driven in opposition while lit
        fast_speed_led <= full_duplex;
        transmit_led <= ~full_duplex;
      end else begin
        fast_speed_led <= 1'b0;
        transmit_led <= 1'b0;
      end
    end
  end

endmodule // sgl_strap_gpio_led

// ### verif/sgl_board.sv
// Board model: strap resistors on the shared pins, outside drivers on the general-purpose pins.
// Assumes the block's enables are active low; a released pin settles to its
// outside driver when enabled, else to its resistor, so a stale level can never pass for a driven one.
module sgl_board (
  // Resistor levels {speed, collision, receive, gpio1, gpio0}
  input wire [4:0] pull,
  // Outside drive on the general-purpose pins
  input wire [1:0] ext,
  input wire [1:0] ext_en,
  // Block side
  input wire gpio0_out,
  input wire gpio0_oe_n,
  input wire gpio1_out,
  input wire gpio1_oe_n,
  input wire receive_led,
  input wire receive_led_oe_n,
  input wire collision_led,
  input wire collision_led_oe_n,
  input wire fast_speed_led,
  input wire fast_speed_led_oe_n,
  // Resolved pin levels
  output wire gpio0_in,
  output wire gpio1_in,
  output wire receive_led_in,
  output wire collision_led_in,
  output wire fast_speed_led_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Management serial clock is unused by this block, so it is held low
  wire mgmt_clk = 1'b0;
  assign gpio0_in = !gpio0_oe_n ? gpio0_out : ext_en[0] ? ext[0] : pull[0];
  assign gpio1_in = !gpio1_oe_n ? gpio1_out : ext_en[1] ? ext[1] : pull[1];
  assign receive_led_in = !receive_led_oe_n ? receive_led : pull[2];
  assign collision_led_in = !collision_led_oe_n ? collision_led : pull[3];
  assign fast_speed_led_in = !fast_speed_led_oe_n ? fast_speed_led : pull[4];
endmodule // sgl_board

// ### verif/sgl_chk_assertions.sv
// Checker for strap latching and LED behaviour at the block's ports.
// Bound to every instance of the block; one clock, async low reset.
module sgl_chk #(
  parameter BLINK_CYCLES = 4
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Strap and pin levels
  input wire gpio0_in,
  input wire receive_led_in,
  input wire collision_led_in,
  input wire fast_speed_led_in,
  input wire autoneg_ability_strap,
  input wire repeater_strap,
  // Status
  input wire link_up,
  input wire speed_100,
  input wire full_duplex,
  input wire coding_bypass_mode,
  // LEDs
  input wire collision_led,
  input wire fast_speed_led,
  input wire link_led,
  input wire transmit_led,
  // Configuration
  input wire seven_wire_serial_mode,
  input wire transformer_ratio_strap,
  input wire scrambler_enable,
  input wire fibre_mode,
  input wire autoneg_enable,
  input wire repeater_mode,
  input wire advanced_leds
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Straps are taken at the first edge with reset released
  sequence s_rel;
    $rose(resetn);
  endsequence
  a_mode_strap: assert property (
    s_rel |=> seven_wire_serial_mode == !$past(gpio0_in))
    else $error("interface mode not from strap");
  a_scram_strap: assert property (
    s_rel |=> scrambler_enable == $past(collision_led_in))
    else $error("scrambler not from strap");
  a_fibre_strap: assert property (
    s_rel |=> fibre_mode == !$past(fast_speed_led_in))
    else $error("fibre select not from strap");
  a_aneg_strap: assert property (
    s_rel |=> autoneg_enable == $past(autoneg_ability_strap))
    else $error("autoneg not from strap");
  a_led_style: assert property (
    s_rel |=> ##1 advanced_leds == !$past(receive_led_in, 2))
    else $error("LED style not from strap");
  a_straps_held: assert property (
    $past(resetn, 2) |-> $stable({seven_wire_serial_mode,
      transformer_ratio_strap, scrambler_enable, fibre_mode, autoneg_enable}))
    else $error("strap value changed");
  a_rpt_strap: assert property (
    $past(repeater_strap) |-> repeater_mode)
    else $error("repeater strap ignored");
  a_col_fdx: assert property (
    full_duplex [*2] |-> collision_led)
    else $error("collision LED active in full duplex");
  a_speed_std: assert property (
    (!advanced_leds && link_up) [*2] ##0 $stable(speed_100)
      |-> fast_speed_led == !speed_100)
    else $error("speed LED level wrong");
  a_link_led: assert property (
    (link_up && !seven_wire_serial_mode && !coding_bypass_mode) [*2]
      |-> !link_led)
    else $error("link LED not low on link");
  a_bicolour_pair: assert property (
    advanced_leds && link_up |-> !(fast_speed_led && transmit_led))
    else $error("bicolour halves both high");
endmodule // sgl_chk
bind sgl_strap_gpio_led sgl_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.*);

// ### verif/testbench.sv
// Self-checking bench: AXI4-Lite master tasks, board model, two strap sets.
// Assumes the block's hand-over latencies; blink toggles every 4 cycles.
`include "sgl_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic resetn = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0, pull = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, gpio0_in, gpio0_out, gpio0_oe_n, gpio1_in, gpio1_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire gpio1_oe_n, irq_out, irq_out_oe_n, receive_led_in, receive_led;
  wire receive_led_oe_n, collision_led_in, collision_led, collision_led_oe_n;
  wire fast_speed_led_in, fast_speed_led, fast_speed_led_oe_n, link_led;
  wire transmit_led, seven_wire_serial_mode, transformer_ratio_strap;
  wire scrambler_enable, fibre_mode, autoneg_enable, repeater_mode;
  wire advanced_leds;
  logic [2:0] tech_sel_strap = 0;
  logic autoneg_ability_strap = 0, repeater_strap = 0, rx_active = 0;
  logic tx_active = 0, collision = 0, link_up = 0, speed_100 = 0;
  logic full_duplex = 0, coding_bypass_mode = 0, bypass_signal_detect = 0;
  logic [7:0] irq_events = 0;
  logic [1:0] ext = 0, ext_en = 0;
  int mismatches = 0, n_tests = 0, tg[3];

  always #25 clk = ~clk;
  sgl_strap_gpio_led #(.BLINK_CYCLES(4)) DUT (.*);
  sgl_board board (.*);

  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    cmp(s_axi_bresp, r);
  endtask
  task rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
          input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    cmp(s_axi_rresp, r);
    cmp(s_axi_rdata & m, e);
  endtask
  // Pulls are {speed, collision, receive, gpio1, gpio0}; s = {tech, aneg}
  task rst(input logic [4:0] p, input logic [3:0] s);
    @(posedge clk);
    resetn <= 0;
    pull <= p;
    {tech_sel_strap, autoneg_ability_strap} <= s;
    {link_up, rx_active, tx_active, collision, ext_en} <= 0;
    repeat (3) @(posedge clk);
    resetn <= 1;
    repeat (4) @(posedge clk);
  endtask
  task ev(input logic [7:0] e);
    irq_events <= e;
    @(posedge clk);
    irq_events <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Counts level changes of {receive, transmit, collision} LEDs
  task blink;
    logic [2:0] p, v;
    tg = '{0, 0, 0};
    p = {receive_led, transmit_led, collision_led};
    repeat (24) begin
      @(posedge clk);
      v = {receive_led, transmit_led, collision_led};
      for (int i = 0; i < 3; i++) tg[i] += (v[i] !== p[i]);
      p = v;
    end
  endtask
  task results;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    // Hang guard, well past the expected run of under a thousand cycles
    #(50 * 8000);
    mismatches++;
    results;
  end

  initial begin
    rst(5'b10110, 4'b0100);
    rd(`SGL_OFS_STRAPS, 32'h1ff, 32'h00b, `SGL_RESP_OKAY);
    rd(`SGL_OFS_STATUS, 32'h1f, 32'h04, `SGL_RESP_OKAY);
    rd(`SGL_OFS_ADVERT, 32'h1f, 32'h04, `SGL_RESP_OKAY);
    wr(`SGL_OFS_ADVERT, 32'h1f, `SGL_RESP_OKAY);
    rd(`SGL_OFS_ADVERT, 32'h1f, 32'h04, `SGL_RESP_OKAY);
    rd(5'h14, 32'hffffffff, 32'h0, `SGL_RESP_SLVERR);
    wr(5'h18, 32'h1, `SGL_RESP_SLVERR);
    for (int i = 0; i < 2; i++) begin
      ext <= {i[0], ~i[0]};
      ext_en <= 2'b11;
      rd(`SGL_OFS_PINCTL, 32'h3c0, {i[0], 1'b1, ~i[0], 1'b1, 6'h00},
         `SGL_RESP_OKAY);
    end
    ext_en <= 0;
    for (int i = 0; i < 2; i++) begin
      wr(`SGL_OFS_PINCTL, i ? 32'h280 : 32'h0, `SGL_RESP_OKAY);
      repeat (2) @(posedge clk);
      cmp({gpio1_oe_n, gpio0_oe_n, gpio1_in, gpio0_in}, {2'b00, i[0], i[0]});
    end
    cmp({seven_wire_serial_mode, transformer_ratio_strap, scrambler_enable,
         fibre_mode, autoneg_enable, repeater_mode, advanced_leds},
        7'b1100000);
    cmp({receive_led_oe_n, collision_led_oe_n, fast_speed_led_oe_n},
        3'b000);
    wr(`SGL_OFS_PINCTL, 32'h4140, `SGL_RESP_OKAY);
    wr(`SGL_OFS_IRQCTL, 32'h01, `SGL_RESP_OKAY);
    ev(8'h02);
    cmp(irq_out_oe_n, 1);
    ev(8'h01);
    cmp({irq_out_oe_n, irq_out}, 2'b01);
    wr(`SGL_OFS_IRQCTL, 32'h0301, `SGL_RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp(irq_out_oe_n, 1);
    wr(`SGL_OFS_PINCTL, 32'h8140, `SGL_RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp(repeater_mode, 1);
    repeater_strap <= 1;
    wr(`SGL_OFS_PINCTL, 32'h0140, `SGL_RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp(repeater_mode, 1);
    repeater_strap <= 0;
    repeat (2) @(posedge clk);
    cmp(repeater_mode, 0);
    {link_up, speed_100, rx_active, tx_active, collision} <= 5'h1f;
    blink;
    cmp({tg[2] > 2, tg[1] > 2, tg[0] > 2, link_led, fast_speed_led},
        5'b11110);
    full_duplex <= 1;
    speed_100 <= 0;
    repeat (2) @(posedge clk);
    blink;
    cmp({tg[0] == 0, collision_led, fast_speed_led}, 3'b111);
    $display("test strap set one done");
    rst(5'b01001, 4'b1111);
    cmp({seven_wire_serial_mode, transformer_ratio_strap, scrambler_enable,
         fibre_mode, autoneg_enable, repeater_mode, advanced_leds},
        7'b0011101);
    rd(`SGL_OFS_STATUS, 32'h1f, 32'h1f, `SGL_RESP_OKAY);
    link_up <= 1;
    full_duplex <= 1;
    repeat (3) @(posedge clk);
    cmp({link_led, fast_speed_led, transmit_led}, 3'b010);
    full_duplex <= 0;
    repeat (3) @(posedge clk);
    cmp({link_led, fast_speed_led, transmit_led}, 3'b001);
    coding_bypass_mode <= 1;
    bypass_signal_detect <= 1;
    repeat (2) @(posedge clk);
    cmp(link_led, 1);
    $display("test strap set two done");
    results;
  end
endmodule // testbench
